// File: design/glc_top.sv
// glc_top.sv: guard lock interlock controller with Avalon-MM registers
// assumes asynchronous guard pins, one 250 MHz clock, synchronous reset
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "glc_params.svh"
module glc_top
#(
    parameter int TICK_CYCLES = `GLC_TICK_CYCLES
)
(
    // clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst_n,
    // avalon-mm slave
    input  wire logic [`GLC_ADDR_W-1:0] i_avs_address,
    input  wire logic                   i_avs_read,
    input  wire logic                   i_avs_write,
    input  wire logic [`GLC_DW-1:0]     i_avs_writedata,
    output var logic  [`GLC_DW-1:0]     o_avs_readdata,
    output logic                        o_avs_waitrequest,
    // guard lock pins
    input  wire logic                   i_unlock_req,
    input  wire logic                   i_lock_fb,
    input  wire logic                   i_door_closed,
    output var logic                    o_lock_drive,
    output var logic                    o_safe,
    output var logic                    o_fault_flag_out,
    // interrupt
    output var logic                    o_irq
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    glc_in_if pins ();

    logic                       tick;
    glc_pkg::glc_state_e        state;
    glc_pkg::glc_state_e        next_state;
    logic [`GLC_MS_W-1:0]       rel_cnt;
    logic [`GLC_MS_W-1:0]       next_rel_cnt;
    logic [`GLC_MS_W-1:0]       fb_cnt;
    logic [`GLC_MS_W-1:0]       next_fb_cnt;
    logic [`GLC_MS_W-1:0]       rel_target;
    logic [`GLC_MS_W-1:0]       fb_target;
    logic                       fb_pend;
    logic                       next_fb_pend;
    logic                       next_drive;
    logic                       next_safe;
    logic                       fault_tmo;
    logic                       next_fault_tmo;
    logic                       fault_door;
    logic                       next_fault_door;
    logic                       next_fault_out;
    logic                       lock_lvl;
    logic                       fb_locked;
    logic                       door_mode;
    logic                       fb_bad;
    logic                       fclr;
    logic [`GLC_CTRL_W-1:0]     ctrl;
    logic [`GLC_CTRL_W-1:0]     next_ctrl;
    logic [`GLC_SEL_W-1:0]      rel_sel;
    logic [`GLC_SEL_W-1:0]      next_rel_sel;
    logic [`GLC_SEL_W-1:0]      fb_sel;
    logic [`GLC_SEL_W-1:0]      next_fb_sel;
    logic [`GLC_IRQ_W-1:0]      irq_stat;
    logic [`GLC_IRQ_W-1:0]      next_irq_stat;
    logic [`GLC_IRQ_W-1:0]      irq_en;
    logic [`GLC_IRQ_W-1:0]      next_irq_en;
    logic [`GLC_IRQ_W-1:0]      irq_ev;
    logic [`GLC_IRQ_W-1:0]      irq_clr;
    logic                       next_irq;
    logic                       ack;
    logic                       next_ack;
    logic                       wr_en;
    logic [`GLC_DW-1:0]         status;
    logic [`GLC_DW-1:0]         rd_mux;
    logic [`GLC_DW-1:0]         next_rdata;

    // ------------------------------------------------------------------
    // input synchroniser and millisecond tick
    // ------------------------------------------------------------------
    glc_sync u_sync
    (
        .i_ref_clk     (i_ref_clk),
        .i_rst_n       (i_rst_n),
        .i_unlock_req  (i_unlock_req),
        .i_lock_fb     (i_lock_fb),
        .i_door_closed (i_door_closed),
        .pins          (pins.src)
    );

    glc_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick
    (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .o_tick    (tick)
    );

    // ------------------------------------------------------------------
    // delay tables in milliseconds
    // ------------------------------------------------------------------
    function automatic logic [`GLC_MS_W-1:0] rel_ms
        (input logic [`GLC_SEL_W-1:0] sel);
        logic [`GLC_MS_W-1:0] r;
        if (sel <= `GLC_REL_SEG1_LAST)
            r = `GLC_MS_W'(sel) * `GLC_REL_STEP1_MS;
        else if (sel <= `GLC_REL_SEG2_LAST)
            r = `GLC_REL_SEG2_BASE + `GLC_MS_W'(sel - `GLC_REL_SEG2_FIRST)
                * `GLC_REL_STEP2_MS;
        else
            r = `GLC_REL_SEG3_BASE + `GLC_MS_W'(sel - `GLC_REL_SEG3_FIRST)
                * `GLC_REL_STEP3_MS;
        return r;
    endfunction : rel_ms

    function automatic logic [`GLC_MS_W-1:0] fb_ms
        (input logic [`GLC_SEL_W-1:0] sel);
        logic [`GLC_MS_W-1:0] r;
        if (sel <= `GLC_FB_SEG1_LAST)
            r = `GLC_FB_SEG1_BASE + `GLC_MS_W'(sel) * `GLC_FB_STEP1_MS;
        else if (sel <= `GLC_FB_SEG2_LAST)
            r = `GLC_FB_SEG2_BASE + `GLC_MS_W'(sel - `GLC_FB_SEG2_FIRST)
                * `GLC_FB_STEP2_MS;
        else
            r = `GLC_FB_SEG3_BASE + `GLC_MS_W'(sel - `GLC_FB_SEG3_FIRST)
                * `GLC_FB_STEP3_MS;
        return r;
    endfunction : fb_ms

    // ------------------------------------------------------------------
    // lock sequence
    // ------------------------------------------------------------------
    always_comb
    begin
        rel_target = rel_ms(rel_sel);
        fb_target  = fb_ms(fb_sel);
        door_mode  = ~ctrl[`GLC_CTRL_NO_DOOR];
        // drive level that holds the guard locked
        lock_lvl   = ~ctrl[`GLC_CTRL_SPRING];
        // feedback mirrors the solenoid energised state
        fb_locked  = (pins.lock_fb == lock_lvl);

        next_state = state;
        unique case (state)
            glc_pkg::ST_LOCKED:
                if (pins.unlock)
                    next_state = glc_pkg::ST_DELAY;
            glc_pkg::ST_DELAY:
                if (!pins.unlock)
                    next_state = glc_pkg::ST_LOCKED;
                else if (rel_cnt >= rel_target)
                    next_state = glc_pkg::ST_UNLOCKED;
            glc_pkg::ST_UNLOCKED:
                if (!pins.unlock)
                begin
                    if (!door_mode || pins.door)
                        next_state = glc_pkg::ST_LOCKED;
                    else
                        next_state = glc_pkg::ST_RELOCK;
                end
            glc_pkg::ST_RELOCK:
                if (pins.unlock)
                    next_state = glc_pkg::ST_UNLOCKED;
                else if (pins.door)
                    next_state = glc_pkg::ST_LOCKED;
        endcase

        // release delay counted in ticks while waiting
        if (state == glc_pkg::ST_DELAY)
            next_rel_cnt = tick ? rel_cnt + `GLC_MS_W'(1) : rel_cnt;
        else
            next_rel_cnt = '0;

        if (next_state == glc_pkg::ST_UNLOCKED ||
            next_state == glc_pkg::ST_RELOCK)
            next_drive = ~lock_lvl;
        else
            next_drive = lock_lvl;
    end

    // ------------------------------------------------------------------
    // feedback supervision and faults
    // ------------------------------------------------------------------
    always_comb
    begin
        fclr = wr_en && i_avs_address == `GLC_REG_CTRL &&
               i_avs_writedata[`GLC_CTRL_FCLR];

        // each drive change restarts the feedback window
        if (next_drive != o_lock_drive)
        begin
            next_fb_pend = 1'b1;
            next_fb_cnt  = '0;
        end
        else
        begin
            next_fb_pend = fb_pend && (pins.lock_fb != o_lock_drive);
            next_fb_cnt  = (fb_pend && tick && fb_cnt < fb_target) ?
                           fb_cnt + `GLC_MS_W'(1) : fb_cnt;
        end

        // mismatch past the window, or with no drive change pending
        fb_bad = (pins.lock_fb != o_lock_drive) &&
                 (!fb_pend || fb_cnt >= fb_target);

        // hardware set wins over software clear
        next_fault_tmo  = fb_bad || (fault_tmo && !fclr);
        next_fault_door = (door_mode && !pins.door && fb_locked) ||
                          (fault_door && !fclr);
        next_fault_out  = next_fault_tmo || next_fault_door;

        next_safe = !next_fault_out &&
                    next_state == glc_pkg::ST_LOCKED &&
                    !pins.unlock && fb_locked &&
                    (!door_mode || pins.door);
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    always_comb
    begin
        irq_ev = '0;
        irq_ev[`GLC_IRQ_FAULT]  = next_fault_out && !(fault_tmo || fault_door);
        irq_ev[`GLC_IRQ_UNLOCK] = next_state == glc_pkg::ST_UNLOCKED &&
                                  state == glc_pkg::ST_DELAY;
        irq_ev[`GLC_IRQ_SAFE]   = next_safe && !o_safe;
        irq_clr = (wr_en && i_avs_address == `GLC_REG_IRQ_CLR) ?
                  i_avs_writedata[`GLC_IRQ_W-1:0] : '0;
        next_irq_stat = irq_ev | (irq_stat & ~irq_clr);
        next_irq = |(next_irq_stat & next_irq_en);
    end

    // ------------------------------------------------------------------
    // avalon-mm register access, one wait state
    // ------------------------------------------------------------------
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;

    always_comb
    begin
        next_ack = (i_avs_read || i_avs_write) && !ack;
        wr_en    = i_avs_write && ack;

        status = '0;
        status[`GLC_ST_STATE +: `GLC_ST_STATE_W] = state;
        status[`GLC_ST_DRIVE]  = o_lock_drive;
        status[`GLC_ST_SAFE]   = o_safe;
        status[`GLC_ST_FAULT]  = fault_tmo || fault_door;
        status[`GLC_ST_F_TMO]  = fault_tmo;
        status[`GLC_ST_F_DOOR] = fault_door;
        status[`GLC_ST_REQ]    = pins.unlock;
        status[`GLC_ST_FB]     = pins.lock_fb;
        status[`GLC_ST_DOOR]   = pins.door;

        rd_mux = '0;
        case (i_avs_address)
            `GLC_REG_CTRL:     rd_mux[`GLC_CTRL_W-1:0] = ctrl;
            `GLC_REG_REL_SEL:  rd_mux[`GLC_SEL_W-1:0]  = rel_sel;
            `GLC_REG_FB_SEL:   rd_mux[`GLC_SEL_W-1:0]  = fb_sel;
            `GLC_REG_STATUS:   rd_mux = status;
            `GLC_REG_IRQ_STAT: rd_mux[`GLC_IRQ_W-1:0]  = irq_stat;
            `GLC_REG_IRQ_EN:   rd_mux[`GLC_IRQ_W-1:0]  = irq_en;
            default:           rd_mux = '0;
        endcase
        next_rdata = (i_avs_read && !ack) ? rd_mux : o_avs_readdata;

        next_ctrl   = ctrl;
        next_rel_sel = rel_sel;
        next_fb_sel = fb_sel;
        next_irq_en = irq_en;
        if (wr_en)
        begin
            case (i_avs_address)
                `GLC_REG_CTRL:
                    next_ctrl = i_avs_writedata[`GLC_CTRL_W-1:0];
                `GLC_REG_REL_SEL:
                    next_rel_sel = i_avs_writedata[`GLC_SEL_W-1:0];
                `GLC_REG_FB_SEL:
                    next_fb_sel = i_avs_writedata[`GLC_SEL_W-1:0];
                `GLC_REG_IRQ_EN:
                    next_irq_en = i_avs_writedata[`GLC_IRQ_W-1:0];
                default:
                    next_ctrl = ctrl;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            state            <= glc_pkg::ST_LOCKED;
            rel_cnt          <= '0;
            fb_cnt           <= '0;
            fb_pend          <= 1'b1;
            o_lock_drive     <= ~1'(`GLC_CTRL_RST >> `GLC_CTRL_SPRING);
            o_safe           <= 1'b0;
            fault_tmo        <= 1'b0;
            fault_door       <= 1'b0;
            o_fault_flag_out <= 1'b0;
            ctrl             <= `GLC_CTRL_RST;
            rel_sel          <= `GLC_REL_SEL_RST;
            fb_sel           <= `GLC_FB_SEL_RST;
            irq_stat         <= '0;
            irq_en           <= '0;
            o_irq            <= 1'b0;
            ack              <= 1'b0;
            o_avs_readdata   <= '0;
        end
        else
        begin
            state            <= next_state;
            rel_cnt          <= next_rel_cnt;
            fb_cnt           <= next_fb_cnt;
            fb_pend          <= next_fb_pend;
            o_lock_drive     <= next_drive;
            o_safe           <= next_safe;
            fault_tmo        <= next_fault_tmo;
            fault_door       <= next_fault_door;
            o_fault_flag_out <= next_fault_out &&
                                next_ctrl[`GLC_CTRL_ERR_EN];
            ctrl             <= next_ctrl;
            rel_sel          <= next_rel_sel;
            fb_sel           <= next_fb_sel;
            irq_stat         <= next_irq_stat;
            irq_en           <= next_irq_en;
            o_irq            <= next_irq;
            ack              <= next_ack;
            o_avs_readdata   <= next_rdata;
        end
    end
endmodule : glc_top
`default_nettype wire

// File: common/glc_params.svh
// glc_params.svh: constants of the guard lock interlock controller
// assumes a 250 MHz reference clock and Avalon-MM register access
// Operation
// - no-door mode: safe output high only when locked, no request, no fault
// - door mode: safe output high only with door closed and guard locked
// - unlock request drops the safe output at once, then unlocks
// - solenoid goes to unlocking only after the release delay elapsed
// - release delay 0-1 s by 100 ms, 1.5-10 s by 0.5 s, 15-25 s
// - lock feedback must follow each drive change within the timeout
// - feedback timeout 10-100 ms, 150 ms-1 s by 50 ms, 1.5-3 s
// - any fault forces the safe output low
// - door mode: door open while feedback shows locked is a fault
// - enabled fault flag output is high while a fault exists
// - no-door mode: request low returns the drive to locking at once
// - door mode: relock only once the door feedback shows closed
// - safe output returns as soon as feedback confirms locked
// - spring option: solenoid de-energised locks, energised unlocks
`ifndef GLC_PARAMS_SVH
`define GLC_PARAMS_SVH

// clock and tick
`define GLC_CLK_MHZ          250
`define GLC_TICK_MS          1
`define GLC_TICK_CYCLES      (`GLC_TICK_MS * 1000 * `GLC_CLK_MHZ)
`define GLC_TICK_W           18
`define GLC_MS_W             15
`define GLC_SEL_W            5

// release delay table
`define GLC_REL_SEG1_LAST    5'h0a
`define GLC_REL_STEP1_MS     15'h0064
`define GLC_REL_SEG2_FIRST   5'h0b
`define GLC_REL_SEG2_LAST    5'h1c
`define GLC_REL_SEG2_BASE    15'h05dc
`define GLC_REL_STEP2_MS     15'h01f4
`define GLC_REL_SEG3_FIRST   5'h1d
`define GLC_REL_SEG3_BASE    15'h3a98
`define GLC_REL_STEP3_MS     15'h1388

// feedback timeout table
`define GLC_FB_SEG1_LAST     5'h09
`define GLC_FB_SEG1_BASE     15'h000a
`define GLC_FB_STEP1_MS      15'h000a
`define GLC_FB_SEG2_FIRST    5'h0a
`define GLC_FB_SEG2_LAST     5'h1b
`define GLC_FB_SEG2_BASE     15'h0096
`define GLC_FB_STEP2_MS      15'h0032
`define GLC_FB_SEG3_FIRST    5'h1c
`define GLC_FB_SEG3_BASE     15'h05dc
`define GLC_FB_STEP3_MS      15'h01f4

// register map, byte addresses
`define GLC_ADDR_W           8
`define GLC_DW               32
`define GLC_REG_CTRL         8'h00
`define GLC_REG_REL_SEL      8'h04
`define GLC_REG_FB_SEL       8'h08
`define GLC_REG_STATUS       8'h0c
`define GLC_REG_IRQ_STAT     8'h10
`define GLC_REG_IRQ_CLR      8'h14
`define GLC_REG_IRQ_EN       8'h18

// control fields
`define GLC_CTRL_W           3
`define GLC_CTRL_NO_DOOR     0
`define GLC_CTRL_SPRING      1
`define GLC_CTRL_ERR_EN      2
`define GLC_CTRL_FCLR        3
`define GLC_CTRL_RST         3'h2
`define GLC_REL_SEL_RST      5'h05
`define GLC_FB_SEL_RST       5'h09

// status fields
`define GLC_ST_STATE         0
`define GLC_ST_STATE_W       2
`define GLC_ST_DRIVE         2
`define GLC_ST_SAFE          3
`define GLC_ST_FAULT         4
`define GLC_ST_F_TMO         5
`define GLC_ST_F_DOOR        6
`define GLC_ST_REQ           7
`define GLC_ST_FB            8
`define GLC_ST_DOOR          9

// interrupt events
`define GLC_IRQ_W            3
`define GLC_IRQ_FAULT        0
`define GLC_IRQ_UNLOCK       1
`define GLC_IRQ_SAFE         2

`endif

// File: common/glc_pkg.sv
// glc_pkg.sv: types of the guard lock interlock controller
// assumes glc_params.svh for all numeric constants
package glc_pkg;

    // sequence of the guard lock
    typedef enum logic [1:0] {
        ST_LOCKED   = 2'b00,
        ST_DELAY    = 2'b01,
        ST_UNLOCKED = 2'b10,
        ST_RELOCK   = 2'b11
    } glc_state_e;

endpackage : glc_pkg

// File: common/glc_in_if.sv
// glc_in_if.sv: filtered guard inputs passed from synchroniser to core
// assumes one clock domain on both ends
`timescale 1ns/1ps
`default_nettype none
interface glc_in_if;
    logic unlock;
    logic lock_fb;
    logic door;

    modport src (output unlock, output lock_fb, output door);
    modport dst (input unlock, input lock_fb, input door);
endinterface : glc_in_if
`default_nettype wire

// File: design/glc_sync.sv
// glc_sync.sv: three-stage synchroniser for the guard pins
// assumes asynchronous pins; a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module glc_sync
(
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    // pins
    input  wire logic i_unlock_req,
    input  wire logic i_lock_fb,
    input  wire logic i_door_closed,
    // filtered levels
    glc_in_if.src     pins
);
    localparam int N = 3;

    logic [N-1:0] raw;
    logic [N-1:0] ff1;
    logic [N-1:0] ff2;
    logic [N-1:0] ff3;
    logic [N-1:0] filt;
    logic [N-1:0] next_filt;

    assign raw = {~i_door_closed, i_lock_fb, i_unlock_req};

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_bit
            always_comb
            begin
                next_filt[g] = (ff2[g] == ff3[g]) ? ff3[g] : filt[g];
            end

            always_ff @(posedge i_ref_clk)
            begin
                if (!i_rst_n)
                begin
                    ff1[g]  <= 1'b0;
                    ff2[g]  <= 1'b0;
                    ff3[g]  <= 1'b0;
                    filt[g] <= 1'b0;
                end
                else
                begin
                    ff1[g]  <= raw[g];
                    ff2[g]  <= ff1[g];
                    ff3[g]  <= ff2[g];
                    filt[g] <= next_filt[g];
                end
            end
        end
    endgenerate

    assign pins.unlock  = filt[0];
    assign pins.lock_fb = filt[1];
    assign pins.door    = ~filt[2]; // stored inverted: reset reads closed
endmodule : glc_sync
`default_nettype wire

// File: design/glc_tick.sv
// glc_tick.sv: divider giving a one-cycle pulse every millisecond
// assumes the reference clock; TICK_CYCLES may be shortened in simulation
`timescale 1ns/1ps
`default_nettype none
`include "glc_params.svh"
module glc_tick
#(
    parameter int TICK_CYCLES = `GLC_TICK_CYCLES
)
(
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    // tick
    output var logic  o_tick
);
    logic [`GLC_TICK_W-1:0] cnt;
    logic [`GLC_TICK_W-1:0] next_cnt;
    logic                   next_tick;
    logic                   wrap;

    always_comb
    begin
        wrap      = (cnt == `GLC_TICK_W'(TICK_CYCLES - 1));
        next_cnt  = wrap ? '0 : cnt + `GLC_TICK_W'(1);
        next_tick = wrap;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            cnt    <= '0;
            o_tick <= 1'b0;
        end
        else
        begin
            cnt    <= next_cnt;
            o_tick <= next_tick;
        end
    end
endmodule : glc_tick
`default_nettype wire

// File: tb/glc_properties.sv
// glc_properties.sv: port timing checks for the guard lock controller
// assumes the spring option stays selected for the whole run
`timescale 1ns/1ps
`default_nettype none
module glc_properties
(
    // clock, reset and watched ports
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_avs_write,
    input wire logic i_unlock_req,
    input wire logic i_lock_fb,
    input wire logic i_door_closed,
    input wire logic o_lock_drive,
    input wire logic o_safe,
    input wire logic o_fault_flag_out
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    property p_no_req; o_safe |-> !$past(i_unlock_req, 5); endproperty
    a_no_req: assert property (p_no_req)
        else $error("safe high while unlock requested");
    property p_drop;
        $rose(i_unlock_req) ##0 i_unlock_req[*6] |=> !o_safe;
    endproperty
    a_drop: assert property (p_drop)
        else $error("safe not dropped after unlock request");
    property p_late; $rose(o_lock_drive) |-> $past(i_unlock_req, 6); endproperty
    a_late: assert property (p_late)
        else $error("drive unlocked without held request");
    property p_fault; o_fault_flag_out |-> !o_safe; endproperty
    a_fault: assert property (p_fault)
        else $error("safe high during fault");
    property p_sticky;
        $fell(o_fault_flag_out) |-> $past(i_avs_write, 2)
            || $past(i_avs_write, 3);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("fault flag dropped without clear");
    property p_relock;
        $fell(i_unlock_req) ##1 (!i_unlock_req && i_door_closed)[*8]
            |=> !o_lock_drive;
    endproperty
    a_relock: assert property (p_relock)
        else $error("drive not relocked after request release");
    property p_back; $rose(o_safe) |-> $past(i_lock_fb, 5) == o_lock_drive;
    endproperty
    a_back: assert property (p_back)
        else $error("safe rose without locked feedback");
    property p_spring; o_safe |-> !o_lock_drive; endproperty
    a_spring: assert property (p_spring)
        else $error("safe high with solenoid energised");
    c_unlock: cover property ($rose(o_lock_drive));
    c_fault: cover property ($rose(o_fault_flag_out));
    c_safe: cover property ($rose(o_safe));
endmodule : glc_properties
bind glc_top glc_properties u_props (.i_ref_clk, .i_rst_n, .i_avs_write,
    .i_unlock_req, .i_lock_fb, .i_door_closed, .o_lock_drive, .o_safe,
    .o_fault_flag_out);
`default_nettype wire

// File: tb/glc_lock_model.sv
// glc_lock_model.sv: solenoid feedback contact and door sensor
// assumes the bench opens the door and may jam the contact
`timescale 1ns/1ps
`default_nettype none
module glc_lock_model
#(
    parameter int FOLLOW = 50
)
(
    // solenoid, contact and door
    input  wire logic i_clk,
    input  wire logic i_drive,
    input  wire logic i_stuck,
    input  wire logic i_open,
    output var logic  o_fb,
    output var logic  o_door
);
    int cnt = 0;
    initial o_fb = 1'b0;
    assign o_door = !i_open;
    always @(posedge i_clk)
    begin
        cnt <= (o_fb == i_drive || i_stuck) ? 0 : cnt + 1;
        if (cnt == FOLLOW)
            o_fb <= i_drive;
    end
endmodule : glc_lock_model
`default_nettype wire

// File: tb/tb.sv
// tb.sv: register and guard sequences for the guard lock controller
// assumes the 1 ms tick shortened to 10 clock cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        req = 1'b0;
    logic        stuck = 1'b0;
    logic        door_open = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q;
    logic        waitreq, drive, safe, fault, irq, fb, door;
    int          error_cnt = 0;
    int          samples_checked = 0;
    logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1c, 8'h0c, 8'h10};
    logic [31:0] rv [7] = '{32'h2, 32'h5, 32'h9, 32'h0, 32'h0, 32'h208, 32'h4};
    glc_top #(.TICK_CYCLES(10)) u_dut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdat), .o_avs_readdata(rdat),
        .o_avs_waitrequest(waitreq), .i_unlock_req(req), .i_lock_fb(fb),
        .i_door_closed(door), .o_lock_drive(drive), .o_safe(safe),
        .o_fault_flag_out(fault), .o_irq(irq));
    glc_lock_model u_lock (.i_clk(clk), .i_drive(drive), .i_stuck(stuck),
        .i_open(door_open), .o_fb(fb), .o_door(door));
    initial forever #2 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk);
        while (waitreq !== 1'b0)
            @(posedge clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rchk
    // drive must hold off lo cycles, then reach v within hi cycles
    task automatic drv(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        cyc(lo);
        chk(drive, !v);
        while (drive !== v && n < hi)
        begin
            @(posedge clk);
            n++;
        end
        chk(drive, v);
    endtask : drv
    task automatic conclude();
        $display("mismatches %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    initial
    begin
        cyc(40000);
        error_cnt++;
        conclude();
    end
    initial
    begin
        cyc(6);
        rst_n <= 1'b1;
        cyc(20);
        chk(safe, 1'b1);
        chk(fault, 1'b0);
        bus(1'b1, 8'h1c, 32'hff);
        for (int i = 0; i < 7; i++)
            rchk(ra[i], rv[i]);
        bus(1'b1, 8'h18, 32'h7);
        bus(1'b1, 8'h00, 32'h6);
        bus(1'b1, 8'h04, 32'h1);
        bus(1'b1, 8'h14, 32'h7);
        cyc(2);
        chk(irq, 1'b0);
        // door mode: unlock, open, release, relock once closed
        req <= 1'b1;
        cyc(8);
        chk(safe, 1'b0);
        drv(1'b1, 980, 100);
        rchk(8'h10, 32'h2);
        chk(irq, 1'b1);
        bus(1'b1, 8'h14, 32'h2);
        cyc(2);
        chk(irq, 1'b0);
        cyc(100);
        door_open <= 1'b1;
        cyc(20);
        chk(fault, 1'b0);
        req <= 1'b0;
        cyc(100);
        chk(drive, 1'b1);
        door_open <= 1'b0;
        drv(1'b0, 0, 20);
        cyc(100);
        chk(safe, 1'b1);
        // request dropped inside the release delay
        req <= 1'b1;
        cyc(500);
        req <= 1'b0;
        cyc(1000);
        chk(drive, 1'b0);
        chk(safe, 1'b1);
        // door opened while locked
        door_open <= 1'b1;
        cyc(10);
        chk(fault, 1'b1);
        chk(safe, 1'b0);
        door_open <= 1'b0;
        cyc(10);
        chk(fault, 1'b1);
        bus(1'b1, 8'h00, 32'he);
        cyc(4);
        chk(fault, 1'b0);
        // jammed feedback contact
        bus(1'b1, 8'h04, 32'h0);
        stuck <= 1'b1;
        req <= 1'b1;
        drv(1'b1, 0, 30);
        cyc(900);
        chk(fault, 1'b0);
        cyc(200);
        chk(fault, 1'b1);
        chk(safe, 1'b0);
        stuck <= 1'b0;
        req <= 1'b0;
        drv(1'b0, 0, 30);
        bus(1'b1, 8'h00, 32'he);
        cyc(4);
        chk(fault, 1'b0);
        chk(safe, 1'b1);
        // first step of the second delay segment
        bus(1'b1, 8'h04, 32'hb);
        req <= 1'b1;
        drv(1'b1, 14990, 100);
        cyc(100);
        req <= 1'b0;
        drv(1'b0, 0, 30);
        cyc(100);
        // no-door mode ignores the door pin
        bus(1'b1, 8'h00, 32'h7);
        bus(1'b1, 8'h04, 32'h0);
        door_open <= 1'b1;
        cyc(10);
        chk(safe, 1'b1);
        req <= 1'b1;
        drv(1'b1, 0, 30);
        cyc(100);
        req <= 1'b0;
        drv(1'b0, 0, 30);
        cyc(100);
        chk(safe, 1'b1);
        chk(fault, 1'b0);
        door_open <= 1'b0;
        // mask, unmask and clear the interrupt
        bus(1'b1, 8'h18, 32'h0);
        cyc(2);
        chk(irq, 1'b0);
        bus(1'b1, 8'h18, 32'h7);
        cyc(2);
        chk(irq, 1'b1);
        bus(1'b1, 8'h14, 32'h7);
        cyc(2);
        chk(irq, 1'b0);
        conclude();
    end
endmodule : tb
`default_nettype wire
